// >>> hdl/flsq_top.sv
// Purpose: Two-cycle flash command sequencer with lock bits and status.
// Assumes: Host writes and reads are one-cycle strobes on mclk.
// Notes: Array program and erase are done outside; this block times them.
//
// Contract
// - 77h then D0h at block top locks block
// - Lock program completion shown by ready flag
// - 71h then D0h captures block lock state
// - Locked block refuses program and erase
// - Only erase returns lock bit to one
// - Lock disable unlocks all, keeps bits
// - Erase under disable ignores and sets locks
// - Ready low during operations, high after reset
// - Status byte ready D7, erase D5, program D4
// - Clear status zeroes both error flags
// - Pending error refuses program, erase, lock program commands
// - Status mode reads return status byte
// - Bad command, or bad second cycle except after 71h, sets both
// - FFh second cycle aborts into read array, except after 40h
// - Locked or failed erase flags erase error
// - Locked or failed program flags program error
// - Lock disable suppresses locked block errors
// - FFh enters read array mode
// - 50h runs clear status
// - Upper command byte is ignored
`timescale 1ns/10ps
module flsq_top #(
   parameter logic [11:0] PROG_CYC = 12'h010,  // Program busy cycles.
   parameter logic [11:0] ERASE_CYC = 12'h040, // Block erase cycles.
   parameter logic [11:0] ERALL_CYC = 12'h100, // Erase-all cycles.
   parameter logic [11:0] LOCK_CYC = 12'h010,  // Lock program cycles.
   parameter logic [11:0] RDLK_CYC = 12'h002   // Read-lock cycles.
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [flsq_pkg::ADDR_W-1:0] bus_addr,
   input wire logic [flsq_pkg::DATA_W-1:0] bus_wdata,
   output logic [flsq_pkg::DATA_W-1:0] bus_rdata,
   input wire logic [flsq_pkg::DATA_W-1:0] array_rdata,
   input wire logic lock_disable_ctl,
   input wire logic op_fail,
   output logic seq_ready_flag,
   output logic erase_error_flag,
   output logic program_error_flag,
   output logic lock_state_flag,
   output logic [7:0] flash_status_byte,
   output logic op_start,
   output logic [2:0] op_kind,
   output logic [flsq_pkg::ADDR_W-1:0] op_addr,
   output logic [flsq_pkg::DATA_W-1:0] op_wdata,
   output logic [flsq_pkg::NUM_BLK-1:0] op_blocks
);
   // ----------------------------------------------------------------
   // Decode helpers.
   // ----------------------------------------------------------------
   // True when the address is the highest even word of its block.
   function automatic logic is_block_top(
      input logic [flsq_pkg::ADDR_W-1:0] a);
      logic [flsq_pkg::OFS_W-1:0] ofs;
      ofs = a[flsq_pkg::OFS_W-1:0];
      is_block_top = (ofs == {{(flsq_pkg::OFS_W-1){1'b1}}, 1'b0});
   endfunction
   // Block index of an address.
   function automatic logic [flsq_pkg::BLK_W-1:0] blk_of(
      input logic [flsq_pkg::ADDR_W-1:0] a);
      blk_of = a[flsq_pkg::ADDR_W-1:flsq_pkg::OFS_W];
   endfunction
   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   flsq_pkg::flsq_state_e state_q, state_d; // Sequencer phase.
   logic [7:0] first_q, first_d;           // First-cycle command byte.
   logic [flsq_pkg::ADDR_W-1:0] addr_q, addr_d; // Latched target.
   logic [flsq_pkg::DATA_W-1:0] wdata_q, wdata_d; // Program data.
   flsq_pkg::flsq_op_e kind_q, kind_d;     // Running operation.
   logic [flsq_pkg::NUM_BLK-1:0] blocks_q, blocks_d; // Target set.
   logic [flsq_pkg::CNT_W-1:0] cnt_q, cnt_d; // Busy countdown.
   logic [flsq_pkg::NUM_BLK-1:0] lock_q, lock_d; // 0 means locked.
   logic status_mode_q, status_mode_d;     // Reads return status.
   logic erase_err_q, erase_err_d;
   logic prog_err_q, prog_err_d;
   logic lock_state_q, lock_state_d;
   logic start_q, start_d;
   logic [flsq_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic [7:0] cmd;        // Low command byte of the current write.
   logic err_pending;      // Either error flag set.
   logic [flsq_pkg::NUM_BLK-1:0] eff_unlocked; // Lock view after disable.
   logic [flsq_pkg::BLK_W-1:0] wblk; // Block of the current write.
   logic [7:0] status_byte;
   // Command byte only; upper byte is don't-care.
   assign cmd = bus_wdata[7:0];
   assign err_pending = erase_err_q | prog_err_q;
   assign wblk = blk_of(bus_addr);
   // ----------------------------------------------------------------
   // Effective lock view.
   // ----------------------------------------------------------------
   // The disable control masks locks without touching stored bits,
   // so clearing it brings back the old protection of each block not erased while it was set.
   genvar gi;
   generate
      for (gi = 0; gi < flsq_pkg::NUM_BLK; gi++) begin : g_lock
         assign eff_unlocked[gi] = lock_q[gi] | lock_disable_ctl;
      end
   endgenerate
   // ----------------------------------------------------------------
   // Status byte assembly.
   // ----------------------------------------------------------------
   // Reserved bits read as zero.
   always_comb begin
      status_byte = flsq_pkg::STS_RESERVED;
      status_byte[flsq_pkg::STS_READY_POS] = (state_q != flsq_pkg::FLSQ_BUSY);
      status_byte[flsq_pkg::STS_ERASE_POS] = erase_err_q;
      status_byte[flsq_pkg::STS_PROG_POS] = prog_err_q;
   end
   // ----------------------------------------------------------------
   // Sequencer next-state logic.
   // ----------------------------------------------------------------
   // Writes arriving while busy are ignored; the host is expected to
   // poll ready first, and dropping them keeps the latched target safe.
   always_comb begin
      state_d = state_q;
      first_d = first_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      kind_d = kind_q;
      blocks_d = blocks_q;
      cnt_d = cnt_q;
      lock_d = lock_q;
      status_mode_d = status_mode_q;
      erase_err_d = erase_err_q;
      prog_err_d = prog_err_q;
      lock_state_d = lock_state_q;
      start_d = 1'b0;
      unique case (state_q)
         flsq_pkg::FLSQ_IDLE: begin
            if (bus_wr) begin
               first_d = cmd;
               addr_d = bus_addr;
               unique case (cmd)
                  flsq_pkg::CMD_READ_ARRAY: begin
                     status_mode_d = 1'b0;
                  end
                  flsq_pkg::CMD_READ_STATUS: begin
                     status_mode_d = 1'b1;
                  end
                  flsq_pkg::CMD_CLEAR_STATUS: begin
                     erase_err_d = 1'b0;
                     prog_err_d = 1'b0;
                  end
                  flsq_pkg::CMD_PROGRAM, flsq_pkg::CMD_BLOCK_ERASE,
                  flsq_pkg::CMD_ERASE_ALL, flsq_pkg::CMD_LOCK_PROGRAM: begin
                     // Refused outright while an error waits.
                     status_mode_d = 1'b1;
                     if (!err_pending) begin
                        state_d = flsq_pkg::FLSQ_SECOND;
                     end
                  end
                  flsq_pkg::CMD_READ_LOCK: begin
                     state_d = flsq_pkg::FLSQ_SECOND;
                  end
                  default: begin
                     // Unknown command byte.
                     erase_err_d = 1'b1;
                     prog_err_d = 1'b1;
                     status_mode_d = 1'b1;
                  end
               endcase
            end
         end
         flsq_pkg::FLSQ_SECOND: begin
            if (bus_wr) begin
               state_d = flsq_pkg::FLSQ_IDLE;
               addr_d = bus_addr;
               wdata_d = bus_wdata;
               blocks_d = '0;
               blocks_d[wblk] = 1'b1;
               if (first_q == flsq_pkg::CMD_PROGRAM) begin
                  // Program data word may be any value.
                  if (eff_unlocked[wblk]) begin
                     kind_d = flsq_pkg::FLSQ_OP_PROGRAM;
                     cnt_d = PROG_CYC;
                     state_d = flsq_pkg::FLSQ_BUSY;
                     start_d = 1'b1;
                  end else begin
                     prog_err_d = 1'b1;
                  end
               end else if (cmd == flsq_pkg::CMD_READ_ARRAY) begin
                  // Abort: first cycle forgotten.
                  status_mode_d = 1'b0;
               end else if (cmd != flsq_pkg::CMD_CONFIRM) begin
                  if (first_q != flsq_pkg::CMD_READ_LOCK) begin
                     erase_err_d = 1'b1;
                     prog_err_d = 1'b1;
                  end
               end else begin
                  unique case (first_q)
                     flsq_pkg::CMD_BLOCK_ERASE: begin
                        if (eff_unlocked[wblk]) begin
                           kind_d = flsq_pkg::FLSQ_OP_ERASE;
                           cnt_d = ERASE_CYC;
                           state_d = flsq_pkg::FLSQ_BUSY;
                           start_d = 1'b1;
                        end else begin
                           erase_err_d = 1'b1;
                        end
                     end
                     flsq_pkg::CMD_ERASE_ALL: begin
                        // Locked blocks are skipped silently.
                        blocks_d = eff_unlocked;
                        kind_d = flsq_pkg::FLSQ_OP_ERASE_ALL;
                        cnt_d = ERALL_CYC;
                        state_d = flsq_pkg::FLSQ_BUSY;
                        start_d = 1'b1;
                     end
                     flsq_pkg::CMD_LOCK_PROGRAM: begin
                        // Target taken from second cycle.
                        if (is_block_top(bus_addr)) begin
                           kind_d = flsq_pkg::FLSQ_OP_LOCK;
                           cnt_d = LOCK_CYC;
                           state_d = flsq_pkg::FLSQ_BUSY;
                           start_d = 1'b1;
                        end
                     end
                     default: begin
                        // Read lock bit status.
                        if (is_block_top(bus_addr)) begin
                           kind_d = flsq_pkg::FLSQ_OP_READ_LOCK;
                           cnt_d = RDLK_CYC;
                           state_d = flsq_pkg::FLSQ_BUSY;
                        end
                     end
                  endcase
               end
            end
         end
         flsq_pkg::FLSQ_BUSY: begin
            // Ready stays low for the whole count.
            if (cnt_q > flsq_pkg::CNT_ONE) begin
               cnt_d = cnt_q - flsq_pkg::CNT_ONE;
            end else begin
               cnt_d = flsq_pkg::CNT_ZERO;
               state_d = flsq_pkg::FLSQ_IDLE;
               unique case (kind_q)
                  flsq_pkg::FLSQ_OP_PROGRAM: begin
                     prog_err_d = prog_err_q | op_fail;
                  end
                  flsq_pkg::FLSQ_OP_ERASE, flsq_pkg::FLSQ_OP_ERASE_ALL: begin
                     if (op_fail) begin
                        erase_err_d = 1'b1;
                     end else begin
                        // Erase alone restores unlock.
                        lock_d = lock_q | blocks_q;
                     end
                  end
                  flsq_pkg::FLSQ_OP_LOCK: begin
                     if (op_fail) begin
                        prog_err_d = 1'b1;
                     end else begin
                        lock_d = lock_q & ~blocks_q;
                     end
                  end
                  default: begin
                     // Stored bit, not the disable view.
                     lock_state_d = |(lock_q & blocks_q);
                  end
               endcase
            end
         end
      endcase
   end
   // Read data: status byte in status mode, else array word.
   always_comb begin
      rdata_d = rdata_q;
      if (bus_rd) begin
         if (status_mode_q) begin
            rdata_d = {8'h00, status_byte};
         end else begin
            rdata_d = array_rdata;
         end
      end
   end
   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   // Reset leaves the sequencer ready with clean errors.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= flsq_pkg::FLSQ_IDLE;
         first_q <= 8'h00;
         addr_q <= '0;
         wdata_q <= '0;
         kind_q <= flsq_pkg::FLSQ_OP_NONE;
         blocks_q <= '0;
         cnt_q <= flsq_pkg::CNT_ZERO;
         lock_q <= flsq_pkg::LOCK_RESET;
         status_mode_q <= 1'b0;
         erase_err_q <= 1'b0;
         prog_err_q <= 1'b0;
         lock_state_q <= 1'b0;
         start_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         state_q <= state_d;
         first_q <= first_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         kind_q <= kind_d;
         blocks_q <= blocks_d;
         cnt_q <= cnt_d;
         lock_q <= lock_d;
         status_mode_q <= status_mode_d;
         erase_err_q <= erase_err_d;
         prog_err_q <= prog_err_d;
         lock_state_q <= lock_state_d;
         start_q <= start_d;
         rdata_q <= rdata_d;
      end
   end
   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign seq_ready_flag = (state_q != flsq_pkg::FLSQ_BUSY);
   assign erase_error_flag = erase_err_q;
   assign program_error_flag = prog_err_q;
   assign lock_state_flag = lock_state_q;
   assign flash_status_byte = status_byte;
   assign bus_rdata = rdata_q;
   assign op_start = start_q;
   assign op_kind = kind_q;
   assign op_addr = addr_q;
   assign op_wdata = wdata_q;
   assign op_blocks = blocks_q;
endmodule // flsq_top

// >>> pkg/flsq_pkg.sv
// Purpose: Shared constants for the flash lock and status sequencer.
// Assumes: 16-bit command bus, eight flash blocks of equal size.
// Notes: Command codes are matched on the low byte only.
package flsq_pkg;
   // ----------------------------------------------------------------
   // Geometry.
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 16;  // Word-bus address width.
   localparam int unsigned DATA_W = 16;  // Command and read data width.
   localparam int unsigned BLK_W = 3;    // Block index width.
   localparam int unsigned NUM_BLK = 8;  // Number of lockable blocks.
   localparam int unsigned OFS_W = ADDR_W - BLK_W; // Offset in a block.
   localparam int unsigned CNT_W = 12;   // Busy counter width.

   // ----------------------------------------------------------------
   // Command codes (low byte).
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
   localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
   localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
   localparam logic [7:0] CMD_READ_LOCK = 8'h71;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;

   // ----------------------------------------------------------------
   // Status byte field positions and reset values.
   // ----------------------------------------------------------------
   localparam int unsigned STS_READY_POS = 7;
   localparam int unsigned STS_ERASE_POS = 5;
   localparam int unsigned STS_PROG_POS = 4;
   localparam logic [7:0] STS_RESERVED = 8'h00;
   localparam logic [NUM_BLK-1:0] LOCK_RESET = {NUM_BLK{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

   // ----------------------------------------------------------------
   // Operation kinds reported to the array macro.
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FLSQ_OP_NONE,
      FLSQ_OP_PROGRAM,
      FLSQ_OP_ERASE,
      FLSQ_OP_ERASE_ALL,
      FLSQ_OP_LOCK,
      FLSQ_OP_READ_LOCK
   } flsq_op_e;

   // Sequencer states.
   typedef enum logic [1:0] {
      FLSQ_IDLE,
      FLSQ_SECOND,
      FLSQ_BUSY
   } flsq_state_e;
endpackage : flsq_pkg

// >>> tb/flash_lock_status_sequencer_tb_top.sv
// Purpose: Self-checking bench for the lock and status sequencer.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: Short busy counts keep the run brief.
`timescale 1ns/10ps
module flash_lock_status_sequencer_tb_top;
   localparam logic [11:0] LCK = 12'h004; // Lock program busy cycles.
   localparam logic [11:0] PRG = 12'h003; // Program busy cycles.
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic [15:0] bus_wdata = 16'h0000;
   logic lock_disable_ctl = 1'b0;
   logic fail_req = 1'b0; // Asks the array model to fail.
   logic [15:0] bus_rdata, array_rdata, op_addr, op_wdata;
   logic op_fail, seq_ready_flag, erase_error_flag, program_error_flag;
   logic lock_state_flag, op_start;
   logic [7:0] flash_status_byte, op_blocks;
   logic [2:0] op_kind;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0; // Cycles run, for the hang limit.
   always #4 mclk = ~mclk;
   flsq_top #(.PROG_CYC(PRG), .ERASE_CYC(12'h004), .ERALL_CYC(12'h005),
      .LOCK_CYC(LCK), .RDLK_CYC(12'h002)) flsq_top_inst (.mclk(mclk),
      .arst_n(arst_n), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .array_rdata(array_rdata), .lock_disable_ctl(lock_disable_ctl),
      .op_fail(op_fail), .seq_ready_flag(seq_ready_flag),
      .erase_error_flag(erase_error_flag),
      .program_error_flag(program_error_flag),
      .lock_state_flag(lock_state_flag),
      .flash_status_byte(flash_status_byte), .op_start(op_start),
      .op_kind(op_kind), .op_addr(op_addr), .op_wdata(op_wdata),
      .op_blocks(op_blocks));
   flsq_array_model flsq_array_model_inst (.bus_addr(bus_addr),
      .seq_ready_flag(seq_ready_flag), .fail_req(fail_req),
      .array_rdata(array_rdata), .op_fail(op_fail));
   // ---------------------------------------------------------------
   // Access tasks.
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] top(input int b);
      return {b[2:0], 13'h1FFE};
   endfunction
   // A low cycle follows each strobe so strobes never merge.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge mclk);
      bus_wr = 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge mclk);
      bus_rd = 1'b0;
      chk(bus_rdata, exp);
      @(negedge mclk);
   endtask
   // Counts busy cycles; the first one passed inside wr.
   task automatic wait_rdy(output int n);
      n = 1;
      while (seq_ready_flag !== 1'b1 && n < 600) begin
         n++;
         @(negedge mclk);
      end
   endtask
   task automatic ec(input logic [1:0] exp);
      chk({14'h0000, erase_error_flag, program_error_flag}, {14'h0000, exp});
   endtask
   task automatic rlock(input int b, input logic exp);
      int n;
      wr(16'h0000, 16'h0071);
      wr(top(b), 16'h00D0);
      wait_rdy(n);
      chk({15'h0000, lock_state_flag}, {15'h0000, exp});
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin : main
      int n;
      repeat (8) @(negedge mclk);
      arst_n = 1'b1;
      @(negedge mclk);
      chk({8'h00, flash_status_byte}, 16'h0080);
      wr(16'h0000, 16'h00FF);
      rd(16'h2468, 16'h2468 ^ 16'hA5A5);
      wr(16'h0000, 16'h0070);
      rd(16'h0002, 16'h0080);
      $display("test reset and read array done");
      wr(top(2), 16'h5577);
      wr(top(2), 16'h12D0);
      chk({15'h0000, seq_ready_flag}, 16'h0000);
      wait_rdy(n);
      chk(16'(n), {4'h0, LCK});
      rlock(2, 1'b0);
      rlock(3, 1'b1);
      rd(16'h0010, 16'h0080);
      $display("test lock program done");
      wr(16'h4100, 16'h0040);
      wr(16'h4100, 16'h1234);
      ec(2'b01);
      rd(16'h0020, 16'h0090);
      wr(top(3), 16'h0077);
      wr(top(3), 16'h00D0);
      ec(2'b11);
      rlock(3, 1'b1);
      wr(16'h0000, 16'h3450);
      ec(2'b00);
      $display("test error refusal done");
      wr(16'h0000, 16'h0020);
      wr(16'h4004, 16'h00D0);
      ec(2'b10);
      wr(16'h0000, 16'h0050);
      lock_disable_ctl = 1'b1;
      wr(16'h4100, 16'h0040);
      wr(16'h4100, 16'hBEEF);
      wait_rdy(n);
      chk(16'(n), {4'h0, PRG});
      chk(op_addr, 16'h4100);
      chk(op_wdata, 16'hBEEF);
      ec(2'b00);
      rlock(2, 1'b0);
      wr(16'h0000, 16'h0020);
      wr(16'h4004, 16'h00D0);
      wait_rdy(n);
      ec(2'b00);
      chk({8'h00, op_blocks}, 16'h0004);
      lock_disable_ctl = 1'b0;
      rlock(2, 1'b1);
      $display("test lock disable done");
      wr(16'h0000, 16'h0033);
      ec(2'b11);
      wr(16'h0000, 16'h0050);
      wr(16'h0000, 16'h0020);
      wr(top(1), 16'h0011);
      ec(2'b11);
      wr(16'h0000, 16'h0050);
      wr(top(5), 16'h0077);
      wr(top(5), 16'h00FF);
      ec(2'b00);
      rd(16'h0100, 16'h0100 ^ 16'hA5A5);
      rlock(5, 1'b1);
      $display("test command errors done");
      fail_req = 1'b1;
      wr(top(4), 16'h0077);
      wr(top(4), 16'h00D0);
      wait_rdy(n);
      ec(2'b01);
      wr(16'h0000, 16'h0050);
      wr(16'h0000, 16'h00A7);
      wr(16'h0000, 16'h00D0);
      wait_rdy(n);
      ec(2'b10);
      fail_req = 1'b0;
      wr(16'h0000, 16'h0050);
      rlock(4, 1'b1);
      $display("test operation failure done");
      stop_test();
   end
endmodule // flash_lock_status_sequencer_tb_top

// >>> tb/flsq_array_model.sv
// Purpose: Behavioural flash array beside the sequencer.
// Assumes: Array data is a fixed function of the address.
// Notes: Failure is only reported when the bench asks for it.
`timescale 1ns/10ps
module flsq_array_model (
   input wire logic [15:0] bus_addr,
   input wire logic seq_ready_flag,
   input wire logic fail_req,
   output logic [15:0] array_rdata,
   output logic op_fail
);
   // Data differs from the address so a wrong path shows at once.
   // Failure stays low outside busy so no stale verdict leaks.
   always_comb begin
      array_rdata = bus_addr ^ 16'hA5A5;
      op_fail = fail_req && !seq_ready_flag;
   end
endmodule // flsq_array_model

// >>> tb/flsq_assertions.sv
// Purpose: Port checks for the flash lock and status sequencer.
// Assumes: One clock domain, reset low and asynchronous.
// Notes: A pending first cycle is tracked to judge second cycles.
`timescale 1ns/10ps
module flsq_check #(
   parameter logic [11:0] LOCK_CYC = 12'h010,
   parameter logic [11:0] RDLK_CYC = 12'h002
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic bus_wr,
   input wire logic [15:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic seq_ready_flag,
   input wire logic erase_error_flag,
   input wire logic program_error_flag,
   input wire logic lock_state_flag,
   input wire logic [7:0] flash_status_byte,
   input wire logic op_start,
   input wire logic [2:0] op_kind
);
   // ---------------------------------------------------------------
   // Helper state.
   // ---------------------------------------------------------------
   logic [11:0] cnt_q, cnt_d; // Ready-low cycles seen so far.
   logic pend_q, pend_d; // A first cycle awaits its second write.
   logic [7:0] code_q, code_d; // The pending first-cycle code.
   logic [7:0] lo; // Decoded low command byte.
   logic err; // Either error flag.
   logic top; // Write goes to a block top.
   assign lo = bus_wdata[7:0];
   assign err = erase_error_flag | program_error_flag;
   assign top = bus_addr[12:0] == 13'h1FFE;
   // Refused first cycles are not marked pending, so a later write
   // is never judged as a second cycle the design did not expect.
   always_comb begin
      cnt_d = seq_ready_flag ? 12'h000 : cnt_q + 12'h001;
      pend_d = pend_q;
      code_d = code_q;
      if (bus_wr && seq_ready_flag) begin
         pend_d = !pend_q && (lo == 8'h71 ||
            (!err && lo inside {8'h40, 8'h20, 8'hA7, 8'h77}));
         code_d = lo;
      end
   end
   // Registers only.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 12'h000;
         pend_q <= 1'b0;
         code_q <= 8'hFF;
      end else begin
         cnt_q <= cnt_d;
         pend_q <= pend_d;
         code_q <= code_d;
      end
   end
   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   AST_STS_MAP: assert property (
      flash_status_byte == {seq_ready_flag, 1'b0, erase_error_flag,
      program_error_flag, 4'h0}) else $error("status byte mismatch");
   AST_RST_READY: assert property (
      $rose(arst_n) |-> seq_ready_flag && !err)
      else $error("not ready and clean after reset");
   AST_LOCK_GO: assert property (
      pend_q && code_q == 8'h77 && bus_wr && seq_ready_flag &&
      lo == 8'hD0 && top |=> op_start && op_kind == 3'h4 &&
      !seq_ready_flag) else $error("lock program did not start");
   AST_LOCK_LEN: assert property (
      $rose(seq_ready_flag) && op_kind == 3'h4 |-> cnt_q == LOCK_CYC)
      else $error("lock program busy length wrong");
   AST_RDLK_LEN: assert property (
      $rose(seq_ready_flag) && op_kind == 3'h5 |-> cnt_q == RDLK_CYC)
      else $error("read lock busy length wrong");
   AST_ERR_REFUSE: assert property (
      err |=> !op_start) else $error("operation started under error");
   AST_CLEAR: assert property (
      !pend_q && seq_ready_flag && bus_wr && lo == 8'h50 |=> !err)
      else $error("clear left an error flag");
   AST_BAD_CMD: assert property (
      !pend_q && seq_ready_flag && bus_wr && !(lo inside {8'hFF, 8'h70,
      8'h50, 8'h40, 8'h20, 8'hA7, 8'h77, 8'h71, 8'hD0})
      |=> erase_error_flag && program_error_flag)
      else $error("invalid command not flagged");
   AST_SEQ_ERR: assert property (
      pend_q && code_q inside {8'h20, 8'hA7, 8'h77} && seq_ready_flag &&
      bus_wr && !(lo inside {8'hD0, 8'hFF})
      |=> erase_error_flag && program_error_flag)
      else $error("bad second cycle not flagged");
   AST_ABORT: assert property (
      pend_q && code_q inside {8'h20, 8'hA7, 8'h77} && seq_ready_flag &&
      bus_wr && lo == 8'hFF |=> !op_start && $stable(err))
      else $error("abort did not discard command");
   AST_LOCKSTATE_SRC: assert property (
      $changed(lock_state_flag) |-> op_kind == 3'h5)
      else $error("lock state moved without read lock");
   AST_START_BUSY: assert property (
      op_start |-> !seq_ready_flag ##1 !op_start)
      else $error("start pulse without busy");
   // Main scenarios.
   COV_LOCK: cover property (op_start && op_kind == 3'h4);
   COV_RDLK: cover property ($rose(seq_ready_flag) && op_kind == 3'h5);
   COV_ERASE_ERR: cover property (erase_error_flag && !program_error_flag);
endmodule // flsq_check
bind flsq_top flsq_check #(.LOCK_CYC(LOCK_CYC), .RDLK_CYC(RDLK_CYC))
   flsq_check_inst (.mclk(mclk), .arst_n(arst_n), .bus_wr(bus_wr),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .seq_ready_flag(seq_ready_flag), .erase_error_flag(erase_error_flag),
   .program_error_flag(program_error_flag),
   .lock_state_flag(lock_state_flag),
   .flash_status_byte(flash_status_byte), .op_start(op_start),
   .op_kind(op_kind));
